/* ptx_pkg.sv */
// package: register map, field positions and codes of the tx capture block
package ptx_pkg;
  // ***********************************************************
  // register byte offsets
  // ***********************************************************
  localparam logic [11:0] PTX_OFS_SELECT = 12'h100; // bank / port select
  localparam logic [11:0] PTX_OFS_COUNT = 12'h108; // stored capture count
  localparam logic [11:0] PTX_OFS_INT_STS = 12'h110; // sticky events
  localparam logic [11:0] PTX_OFS_INT_MASK = 12'h114; // event enables
  localparam logic [11:0] PTX_OFS_MOD = 12'h164; // insertion enables
  localparam logic [11:0] PTX_OFS_MOD2 = 12'h168; // checksum clear
  localparam logic [11:0] PTX_OFS_SEC = 12'h16c; // buffered seconds
  localparam logic [11:0] PTX_OFS_NS = 12'h170; // buffered nanoseconds
  localparam logic [11:0] PTX_OFS_HDR = 12'h174; // buffered header
  localparam logic [11:0] PTX_OFS_DREQ_SEC = 12'h178; // held seconds
  localparam logic [11:0] PTX_OFS_DREQ_NS = 12'h17c; // held nanoseconds
  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int PTX_SEL_BANK_LSB = 0; // bank select, 3 bits
  localparam int PTX_SEL_PORT_LSB = 4; // port select, 2 bits
  localparam int PTX_MOD_SYNC_BIT = 28; // sync origin insert enable
  localparam int PTX_MOD_TA_BIT = 29; // turnaround insert enable
  localparam int PTX_MOD2_CLR_BIT = 0; // udp checksum clear enable
  localparam int PTX_HDR_CRC_LSB = 20; // source identity crc
  localparam int PTX_HDR_KIND_LSB = 16; // message kind
  localparam int PTX_INT_CAPT_BIT = 0; // capture stored
  localparam int PTX_INT_OVFL_BIT = 1; // capture dropped, buffer full
  localparam int PTX_INT_DREQ_BIT = 2; // delay request time updated
  // ***********************************************************
  // reset values, codes and sizes
  // ***********************************************************
  localparam logic [2:0] PTX_RST_BANK = 3'h0;
  localparam logic [1:0] PTX_RST_PORT = 2'h0;
  localparam logic [2:0] PTX_PORT_BANK = 3'h2; // bank of port registers
  localparam logic [1:0] PTX_THIS_PORT = 2'h0; // port served here
  localparam logic [2:0] PTX_DEPTH = 3'h4; // buffered captures
  localparam logic [3:0] PTX_KIND_SYNC = 4'h0;
  localparam logic [3:0] PTX_KIND_DREQ = 4'h1;
  localparam logic [3:0] PTX_KIND_PDRESP = 4'h3;
  localparam logic [11:0] PTX_CRC_POLY = 12'h80f; // plain default
  localparam logic [11:0] PTX_CRC_INIT = 12'h000; // plain default
  localparam logic [31:0] PTX_RST_WORD = 32'h0000_0000;
endpackage : ptx_pkg

/* ptx_egress_capture.sv */
// module: per-port transmit egress timestamp and header capture
//
// Function
// - zero udp sum when modifying, if enabled
// - buffer four captures of time and header
// - seconds read-only 32 bits, reset zero
// - nanoseconds 30 bits, top two reserved
// - 12-bit crc of source identity stored
// - kind and sequence number stored with time
// - bank and port select gate port registers
// - hold last delay request egress time, only low four seconds bits
// - insert egress time into host sync
// - add turnaround into host pdelay response
`timescale 1ns/1ps
`default_nettype none
module ptx_egress_capture (
  input wire logic pclk, // 250 MHz
  input wire logic presetn, // async, active low
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq, // level, unmasked sticky event
  input wire logic tx_valid, // one frame leaving, one cycle
  input wire logic [31:0] tx_seconds,
  input wire logic [29:0] tx_nanoseconds,
  input wire logic [3:0] tx_kind,
  input wire logic [15:0] tx_sequence,
  input wire logic [79:0] tx_source_identity,
  input wire logic tx_host_sent, // frame originated by host
  input wire logic tx_ipv4_udp, // frame is udp over ipv4
  input wire logic [31:0] tx_turnaround_ns,
  output logic origin_insert, // pulse: write origin time
  output logic [31:0] origin_seconds,
  output logic [29:0] origin_nanoseconds,
  output logic correction_insert, // pulse: add to correction
  output logic [31:0] correction_add_ns,
  output logic udp_sum_zero // pulse: clear udp checksum
);
  import ptx_pkg::*;

  // ***********************************************************
  // crc over the source identity
  // ***********************************************************
  // msb first, one frame per cycle, so fully unrolled
  function automatic logic [11:0] ptx_crc12(input logic [79:0] d);
    logic [11:0] c;
    c = PTX_CRC_INIT;
    for (int i = 79; i >= 0; i--) begin
      if (c[11] ^ d[i]) begin
        c = {c[10:0], 1'b0} ^ PTX_CRC_POLY;
      end else begin
        c = {c[10:0], 1'b0};
      end
    end
    return c;
  endfunction : ptx_crc12

  // ***********************************************************
  // state
  // ***********************************************************
  logic [2:0] bank_q; // bank select
  logic [1:0] port_q; // port select
  logic sync_en_q; // sync_origin_insert_enable
  logic ta_en_q; // turnaround_insert_enable
  logic clr_en_q; // clear_ipv4_udp_sum_enable
  logic [2:0] int_sts_q; // sticky events
  logic [2:0] int_mask_q; // event enables
  logic [2:0] cnt_q; // egress_capture_count
  logic [1:0] wr_q; // next slot to fill
  logic [1:0] rd_q; // oldest slot
  logic [31:0] sec_mem [4]; // capture_seconds per slot
  logic [29:0] ns_mem [4]; // capture_nanoseconds per slot
  logic [31:0] hdr_mem [4]; // header capture per slot
  logic [3:0] dreq_sec_q; // held delay request seconds
  logic [29:0] dreq_ns_q; // held delay request nanoseconds
  logic [31:0] rd_value; // read mux
  logic rd_hit; // address is mapped

  // ***********************************************************
  // bus decode
  // ***********************************************************
  logic acc; // access phase
  logic done; // transfer completes this edge
  logic port_on; // this port's bank is selected
  logic wr_done; // completed write
  logic pop; // consumer takes oldest entry
  logic push; // capture stored
  logic ovfl; // capture dropped
  logic [31:0] hdr_new; // header word of this frame
  logic sync_hit; // host sync, insertion on
  logic ta_hit; // host pdelay response, insertion on
  assign acc = psel & penable;
  assign done = acc & pready;
  assign wr_done = done & pwrite;
  // per-port registers only answer in the port bank for this port
  assign port_on = (bank_q == PTX_PORT_BANK) &&
                   (port_q == PTX_THIS_PORT);
  // header read is last of the three, so it releases the entry
  assign pop = done & ~pwrite & port_on & (paddr == PTX_OFS_HDR) &
               (cnt_q != 3'h0);
  // a full buffer still takes a frame when an entry leaves at once
  assign push = tx_valid & ((cnt_q < PTX_DEPTH) | pop);
  assign ovfl = tx_valid & ~push;
  assign hdr_new = {ptx_crc12(tx_source_identity), tx_kind,
                    tx_sequence};
  assign sync_hit = tx_valid & tx_host_sent & sync_en_q &
                    (tx_kind == PTX_KIND_SYNC);
  assign ta_hit = tx_valid & tx_host_sent & ta_en_q &
                  (tx_kind == PTX_KIND_PDRESP);

  // ***********************************************************
  // read mux
  // ***********************************************************
  // unselected port registers read zero rather than erroring
  always_comb begin
    rd_value = PTX_RST_WORD;
    rd_hit = 1'b1;
    if (paddr == PTX_OFS_SELECT) begin
      rd_value[PTX_SEL_BANK_LSB +: 3] = bank_q;
      rd_value[PTX_SEL_PORT_LSB +: 2] = port_q;
    end else if (paddr == PTX_OFS_COUNT) begin
      rd_value[2:0] = cnt_q;
    end else if (paddr == PTX_OFS_INT_STS) begin
      rd_value[2:0] = int_sts_q;
    end else if (paddr == PTX_OFS_INT_MASK) begin
      rd_value[2:0] = int_mask_q;
    end else if (paddr == PTX_OFS_MOD) begin
      rd_value[PTX_MOD_SYNC_BIT] = sync_en_q & port_on;
      rd_value[PTX_MOD_TA_BIT] = ta_en_q & port_on;
    end else if (paddr == PTX_OFS_MOD2) begin
      rd_value[PTX_MOD2_CLR_BIT] = clr_en_q & port_on;
    end else if (paddr == PTX_OFS_SEC) begin
      rd_value = port_on ? sec_mem[rd_q] : PTX_RST_WORD;
    end else if (paddr == PTX_OFS_NS) begin
      rd_value[29:0] = port_on ? ns_mem[rd_q] : 30'h0;
    end else if (paddr == PTX_OFS_HDR) begin
      rd_value = port_on ? hdr_mem[rd_q] : PTX_RST_WORD;
    end else if (paddr == PTX_OFS_DREQ_SEC) begin
      rd_value[3:0] = port_on ? dreq_sec_q : 4'h0;
    end else if (paddr == PTX_OFS_DREQ_NS) begin
      rd_value[29:0] = port_on ? dreq_ns_q : 30'h0;
    end else begin
      rd_hit = 1'b0; // unmapped
    end
  end

  // ***********************************************************
  // bus answer: one wait cycle, then ready
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= PTX_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~rd_hit;
      if (acc & ~pready & ~pwrite) begin
        prdata <= rd_value; // held until the next read
      end
    end
  end

  // ***********************************************************
  // writable controls
  // ***********************************************************
  // host is trusted to keep clr_en_q steady while the unit runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= PTX_RST_BANK;
      port_q <= PTX_RST_PORT;
      sync_en_q <= 1'b0;
      ta_en_q <= 1'b0;
      clr_en_q <= 1'b0;
      int_mask_q <= 3'h0;
    end else if (wr_done) begin
      if (paddr == PTX_OFS_SELECT) begin
        bank_q <= pwdata[PTX_SEL_BANK_LSB +: 3];
        port_q <= pwdata[PTX_SEL_PORT_LSB +: 2];
      end else if (paddr == PTX_OFS_INT_MASK) begin
        int_mask_q <= pwdata[2:0];
      end else if (paddr == PTX_OFS_MOD && port_on) begin
        sync_en_q <= pwdata[PTX_MOD_SYNC_BIT];
        ta_en_q <= pwdata[PTX_MOD_TA_BIT];
      end else if (paddr == PTX_OFS_MOD2 && port_on) begin
        clr_en_q <= pwdata[PTX_MOD2_CLR_BIT];
      end
    end
  end

  // ***********************************************************
  // capture buffer pointers and count
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      wr_q <= 2'h0;
      rd_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 2'h1;
      end
      if (pop) begin
        rd_q <= rd_q + 2'h1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 3'h1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end

  // ***********************************************************
  // capture slots
  // ***********************************************************
  for (genvar i = 0; i < 4; i++) begin : g_slot
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sec_mem[i] <= PTX_RST_WORD;
        ns_mem[i] <= 30'h0;
        hdr_mem[i] <= PTX_RST_WORD;
      end else if (push && wr_q == 2'(i)) begin
        sec_mem[i] <= tx_seconds;
        ns_mem[i] <= tx_nanoseconds;
        hdr_mem[i] <= hdr_new;
      end
    end
  end

  // ***********************************************************
  // last delay request egress time
  // ***********************************************************
  // kept even when the buffer is full, it feeds delay responses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreq_sec_q <= 4'h0;
      dreq_ns_q <= 30'h0;
    end else if (tx_valid && tx_kind == PTX_KIND_DREQ) begin
      dreq_sec_q <= tx_seconds[3:0];
      dreq_ns_q <= tx_nanoseconds;
    end
  end

  // ***********************************************************
  // frame modification requests
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      origin_insert <= 1'b0;
      origin_seconds <= PTX_RST_WORD;
      origin_nanoseconds <= 30'h0;
      correction_insert <= 1'b0;
      correction_add_ns <= PTX_RST_WORD;
      udp_sum_zero <= 1'b0;
    end else begin
      origin_insert <= sync_hit;
      correction_insert <= ta_hit;
      // checksum cleared only on frames that really get rewritten
      udp_sum_zero <= clr_en_q & tx_ipv4_udp & (sync_hit | ta_hit);
      if (sync_hit) begin
        origin_seconds <= tx_seconds;
        origin_nanoseconds <= tx_nanoseconds;
      end
      if (ta_hit) begin
        correction_add_ns <= tx_turnaround_ns;
      end
    end
  end

  // ***********************************************************
  // interrupt status, read clears, new events win
  // ***********************************************************
  logic [2:0] int_set; // events this cycle
  logic [2:0] int_clr; // bits reported by a finished read
  assign int_set = {tx_valid & (tx_kind == PTX_KIND_DREQ), ovfl, push};
  // only the bits software saw are cleared
  assign int_clr = (done & ~pwrite & (paddr == PTX_OFS_INT_STS)) ?
                   prdata[2:0] : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sts_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      int_sts_q <= (int_sts_q & ~int_clr) | int_set;
      irq <= |(((int_sts_q & ~int_clr) | int_set) & int_mask_q);
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  AST_UDP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_hit | ta_hit) & clr_en_q & tx_ipv4_udp |=> udp_sum_zero)
    else $error("udp checksum clear missing");
  AST_COUNT_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_q <= PTX_DEPTH)
    else $error("capture count above depth");
  AST_PUSH: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid & ~pop & (cnt_q < PTX_DEPTH) |=> cnt_q == $past(cnt_q) + 3'h1)
    else $error("capture not counted");
  AST_NS_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    pready & ~pwrite & (paddr == PTX_OFS_NS) |-> prdata[31:30] == 2'h0)
    else $error("reserved nanosecond bits set");
  AST_CRC: assert property (@(posedge pclk) disable iff (!presetn)
    push & (cnt_q == 3'h0) & ~pop |=>
      hdr_mem[rd_q][31:20] == ptx_crc12($past(tx_source_identity)))
    else $error("source identity crc wrong");
  AST_HDR: assert property (@(posedge pclk) disable iff (!presetn)
    push & (cnt_q == 3'h0) & ~pop |=>
      hdr_mem[rd_q][19:0] == $past({tx_kind, tx_sequence}))
    else $error("kind or sequence not stored");
  AST_DREQ: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid & (tx_kind == PTX_KIND_DREQ) |=>
      (dreq_ns_q == $past(tx_nanoseconds)) &&
      (dreq_sec_q == $past(tx_seconds[3:0])))
    else $error("delay request time not held");
  AST_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    sync_hit |=> origin_insert && origin_seconds == $past(tx_seconds))
    else $error("sync origin insertion wrong");
  AST_TA: assert property (@(posedge pclk) disable iff (!presetn)
    ta_hit |=> correction_insert &&
      correction_add_ns == $past(tx_turnaround_ns))
    else $error("turnaround insertion wrong");
  AST_POP: assert property (@(posedge pclk) disable iff (!presetn)
    pop & ~push |=> cnt_q == $past(cnt_q) - 3'h1 &&
      rd_q == $past(rd_q) + 2'h1)
    else $error("read did not release entry");
endmodule : ptx_egress_capture
`default_nettype wire

/* ptx_tx_model.sv */
// partner: transmit datapath model that hands departing frames to the block
`timescale 1ns/1ps
`default_nettype none
module ptx_tx_model (
  input wire logic pclk,
  output logic tx_valid,
  output logic [31:0] tx_seconds,
  output logic [29:0] tx_nanoseconds,
  output logic [3:0] tx_kind,
  output logic [15:0] tx_sequence,
  output logic [79:0] tx_source_identity,
  output logic tx_host_sent,
  output logic tx_ipv4_udp,
  output logic [31:0] tx_turnaround_ns
);
  // ***********************************************************
  // frame fields, packed into one register
  // ***********************************************************
  logic [195:0] frame_q; // all qualifiers of the departing frame
  assign {tx_seconds, tx_nanoseconds, tx_kind, tx_sequence,
    tx_source_identity, tx_host_sent, tx_ipv4_udp,
    tx_turnaround_ns} = frame_q;
  // quiet datapath at time zero
  initial begin
    tx_valid = 1'b0;
    frame_q = '0;
  end
  // one frame per call, after an idle gap; fields flip once released so a
  // late sample never sees the frame's values by accident
  task automatic send(input int gap, input logic [195:0] f);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    tx_valid <= 1'b1;
    frame_q <= f;
    @(posedge pclk);
    tx_valid <= 1'b0;
    frame_q <= ~f;
  endtask : send
endmodule : ptx_tx_model
`default_nettype wire

/* ptp_tx_egress_timestamp_capture_tb.sv */
// testbench: apb host and scoreboard around the tx capture block
`timescale 1ns/1ps
`default_nettype none
module ptp_tx_egress_timestamp_capture_tb;
  import ptx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tx_seconds, tx_turnaround_ns;
  logic [31:0] origin_seconds, correction_add_ns;
  logic [29:0] tx_nanoseconds, origin_nanoseconds;
  logic [3:0] tx_kind;
  logic [15:0] tx_sequence;
  logic [79:0] tx_source_identity;
  logic tx_valid, tx_host_sent, tx_ipv4_udp;
  logic origin_insert, correction_insert, udp_sum_zero;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h49a13f3c; // xorshift state
  logic [32:0] rd_q[$]; // {error expected, read data}
  logic [63:0] ev_q[$]; // {udp zero, origin kind, ns, value}
  logic [32:0] rd_e;
  logic [63:0] ev_e;
  logic clr_exp = 1'b1; // checksum clear bit as last written
  logic [31:0] sec_a[5];
  logic [29:0] ns_a[5];
  logic [31:0] hdr_a[5];
  logic [31:0] sel_ok = {26'h0, PTX_THIS_PORT, 1'b0, PTX_PORT_BANK};
  logic [3:0] kinds[5] = '{PTX_KIND_SYNC, PTX_KIND_PDRESP, PTX_KIND_SYNC,
    4'h2, PTX_KIND_DREQ};
  logic [11:0] rst_a[8] = '{PTX_OFS_SEC, PTX_OFS_NS, PTX_OFS_HDR,
    PTX_OFS_DREQ_SEC, PTX_OFS_DREQ_NS, PTX_OFS_MOD, PTX_OFS_MOD2,
    PTX_OFS_COUNT};
  ptx_egress_capture uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .tx_valid,
    .tx_seconds, .tx_nanoseconds, .tx_kind, .tx_sequence,
    .tx_source_identity, .tx_host_sent, .tx_ipv4_udp, .tx_turnaround_ns,
    .origin_insert, .origin_seconds, .origin_nanoseconds,
    .correction_insert, .correction_add_ns, .udp_sum_zero);
  ptx_tx_model txm (.pclk, .tx_valid, .tx_seconds, .tx_nanoseconds,
    .tx_kind, .tx_sequence, .tx_source_identity, .tx_host_sent,
    .tx_ipv4_udp, .tx_turnaround_ns);
  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // msb-first crc, worked out here independently of the design
  function automatic logic [11:0] crc12(input logic [79:0] d);
    logic [11:0] c;
    logic fb;
    c = PTX_CRC_INIT;
    for (int i = 79; i >= 0; i--) begin
      fb = c[11] ^ d[i];
      c = {c[10:0], 1'b0};
      if (fb) c = c ^ PTX_CRC_POLY;
    end
    return c;
  endfunction : crc12
  task automatic summarize();
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; reads leave their expectation for the monitor
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic err);
    int n;
    @(posedge pclk);
    if (!w) rd_q.push_back({err, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  // random frame; notes the captured entry and any insertion it causes
  task automatic frame(input int i, input logic [3:0] k, input logic u,
      input logic en, input logic h);
    logic [31:0] s, ta;
    logic [29:0] n;
    logic [15:0] q;
    logic [79:0] id;
    s = rnd();
    ta = rnd();
    n = 30'(rnd());
    q = 16'(rnd());
    id = {rnd(), rnd(), 16'(rnd())};
    sec_a[i] = s;
    ns_a[i] = n;
    hdr_a[i] = {crc12(id), k, q};
    // only host frames are rewritten; checksum cleared only when enabled
    if (en && h && k == PTX_KIND_SYNC) begin
      ev_q.push_back({u & clr_exp, 1'b1, n, s});
    end
    if (en && h && k == PTX_KIND_PDRESP) begin
      ev_q.push_back({u & clr_exp, 1'b0, 30'h0, ta});
    end
    txm.send(i, {s, n, k, q, id, h, u, ta});
  endtask : frame
  // ***********************************************************
  // monitor: oldest note against each result as it appears
  // ***********************************************************
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      rd_e = (rd_q.size() > 0) ? rd_q.pop_front() : 33'h1_dead_beef;
      chk("pslverr", {31'h0, rd_e[32]}, {31'h0, pslverr});
      if (!rd_e[32]) chk("prdata", rd_e[31:0], prdata);
    end
    if (origin_insert === 1'b1 || correction_insert === 1'b1) begin
      ev_e = (ev_q.size() > 0) ? ev_q.pop_front() : '1;
      chk("udp_sum_zero", {31'h0, ev_e[63]}, {31'h0, udp_sum_zero});
      if (ev_e[62]) begin
        chk("origin_seconds", ev_e[31:0], origin_seconds);
        chk("origin_ns", {2'h0, ev_e[61:32]}, {2'h0, origin_nanoseconds});
      end else begin
        chk("correction_add_ns", ev_e[31:0], correction_add_ns);
        chk("origin_insert", 32'h0, {31'h0, origin_insert});
      end
    end
  end
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, PTX_OFS_SELECT, sel_ok, 1'b0);
    foreach (rst_a[i]) apb(1'b0, rst_a[i], PTX_RST_WORD, 1'b0);
    apb(1'b1, PTX_OFS_SEC, 32'hffff_ffff, 1'b0);
    apb(1'b0, PTX_OFS_SEC, 32'h0, 1'b0);
    apb(1'b0, 12'h0f0, 32'h0, 1'b1);
    apb(1'b1, PTX_OFS_MOD2, 32'h1, 1'b0);
    apb(1'b0, PTX_OFS_MOD2, 32'h1, 1'b0);
    apb(1'b1, PTX_OFS_MOD, 32'h3000_0000, 1'b0);
    apb(1'b1, PTX_OFS_INT_MASK, 32'h7, 1'b0);
    // five frames into a four-deep buffer: the last one is dropped;
    // the third is a sync that the host did not send, so no insertion
    for (int i = 0; i < 5; i++) begin
      frame(i, kinds[i], i == 0, 1'b1, i != 2);
    end
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, PTX_OFS_COUNT, {29'h0, PTX_DEPTH}, 1'b0);
    apb(1'b0, PTX_OFS_INT_STS, 32'h7, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, PTX_OFS_SEC, sec_a[i], 1'b0);
      apb(1'b0, PTX_OFS_NS, {2'h0, ns_a[i]}, 1'b0);
      apb(1'b0, PTX_OFS_HDR, hdr_a[i], 1'b0);
    end
    apb(1'b0, PTX_OFS_COUNT, 32'h0, 1'b0);
    apb(1'b0, PTX_OFS_DREQ_SEC, {28'h0, sec_a[4][3:0]}, 1'b0);
    apb(1'b0, PTX_OFS_DREQ_NS, {2'h0, ns_a[4]}, 1'b0);
    // insertion off and events masked: no pulse, no interrupt
    apb(1'b1, PTX_OFS_MOD, 32'h0, 1'b0);
    apb(1'b1, PTX_OFS_INT_MASK, 32'h0, 1'b0);
    frame(0, PTX_KIND_SYNC, 1'b1, 1'b0, 1'b1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, PTX_OFS_SELECT, sel_ok | 32'h10, 1'b0);
    apb(1'b0, PTX_OFS_HDR, 32'h0, 1'b0);
    apb(1'b0, PTX_OFS_COUNT, 32'h1, 1'b0);
    apb(1'b1, PTX_OFS_SELECT, sel_ok, 1'b0);
    apb(1'b0, PTX_OFS_HDR, hdr_a[0], 1'b0);
    apb(1'b0, PTX_OFS_INT_STS, 32'h1, 1'b0);
    apb(1'b0, PTX_OFS_INT_STS, 32'h0, 1'b0);
    // checksum clear off: sync still stamped, checksum left alone
    apb(1'b1, PTX_OFS_MOD2, 32'h0, 1'b0);
    clr_exp = 1'b0;
    apb(1'b1, PTX_OFS_MOD, 32'h1000_0000, 1'b0);
    frame(1, PTX_KIND_SYNC, 1'b1, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    // a result that never appeared leaves its note behind
    chk("pending notes", 32'h0, 32'(rd_q.size() + ev_q.size()));
    summarize();
  end
endmodule : ptp_tx_egress_timestamp_capture_tb
`default_nettype wire
